//--- rtl/dref_regs.sv
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dref_defs.svh"

// Contract
// - Any reset clears the converter enable bit.
// - Any reset clears the pin output enable.
// - Any reset clears the five-bit level select field.
// - Control register bit 7 enables the converter when set.
// - Control bits 3:2 pick positive source: supply, pin, fixed buffer.
// - Control bits 4 and 1:0 ignore writes and read zero.
// - Level register bits 7:5 ignore writes and read zero.
// - Level register bits 4:0 are a read-write 32-level select.
// - All implemented bits reset to zero on every reset.
// - Low-power select set drops negative source; clear drops positive.
// - Output enable routes the voltage to the pin, overriding digital buffers.
// - Digital read of the pin returns zero while in voltage output.
// - Enabled output equals negative plus difference times level over 32.

module dref_regs
#(
  parameter int LEVEL_BITS = 5
)
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic [3:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [3:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pin_digital_in,
  output dref_pkg::dref_cfg_t    cfg,
  output dref_pkg::dref_analog_t ana,
  output logic [LEVEL_BITS:0]    ladder_numerator
);

  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (LEVEL_BITS != 5)
  begin : g_bad_width
    $error("LEVEL_BITS must be 5 to fit the level register");
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic       wr_strobe;
  logic [3:0] wr_addr;
  logic [7:0] wr_byte;
  logic [3:0] rd_addr;
  logic [7:0] rd_byte;
  logic       rd_hit;
  logic       wr_hit;

  function automatic logic addr_known(input logic [3:0] a);
    addr_known = (a == `DREF_CTRL_ADDR) || (a == `DREF_LEVEL_ADDR);
  endfunction

  assign wr_hit = addr_known(wr_addr);
  assign rd_hit = addr_known(rd_addr);

  dref_axil_slave u_bus
  (
    .clk           (clk),
    .rst           (rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wr_strobe     (wr_strobe),
    .wr_addr       (wr_addr),
    .wr_byte       (wr_byte),
    .rd_addr       (rd_addr),
    .rd_byte       (rd_byte),
    .rd_hit        (rd_hit),
    .wr_hit        (wr_hit)
  );

  // ----------------------------------------
  // Pin input synchroniser
  // ----------------------------------------
  // Pin is asynchronous; a change counts once stages two and three agree
  logic [2:0] pin_sync;
  logic       pin_level;
  wire        pin_agree = (pin_sync[1] == pin_sync[2]);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_sync  <= 3'h0;
      pin_level <= 1'b0;
    end
    else
    begin
      pin_sync <= {pin_sync[1:0], pin_digital_in};
      if (pin_agree)
        pin_level <= pin_sync[2];
    end
  end

  // ----------------------------------------
  // Control and level registers
  // ----------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] level_reg;

  wire wr_ctrl  = wr_strobe && (wr_addr == `DREF_CTRL_ADDR);
  wire wr_level = wr_strobe && (wr_addr == `DREF_LEVEL_ADDR);

  // Masking on write keeps unused bits at zero forever
  wire [7:0] next_ctrl  = wr_byte & `DREF_CTRL_MASK;
  wire [7:0] next_level = wr_byte & `DREF_LEVEL_MASK;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_reg  <= `DREF_CTRL_RST;
      level_reg <= `DREF_LEVEL_RST;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= next_ctrl;
      if (wr_level)
        level_reg <= next_level;
    end
  end

  // Reserved source code is stored as written; behaviour is undefined by design
  wire dref_pkg::dref_cfg_t next_cfg =
  '{
    converter_enable:        ctrl_reg[`DREF_EN_BIT],
    low_power_source_select: ctrl_reg[`DREF_LPS_BIT],
    voltage_output_enable:   ctrl_reg[`DREF_OE_BIT],
    positive_source_select:  dref_pkg::dref_src_t'(ctrl_reg[`DREF_PSS_HI:`DREF_PSS_LO]),
    output_level_select:     level_reg[`DREF_LVL_HI:`DREF_LVL_LO]
  };

  // Read mux: stored values, unused bits already zero
  assign rd_byte = (rd_addr == `DREF_CTRL_ADDR)  ? ctrl_reg  :
                   (rd_addr == `DREF_LEVEL_ADDR) ? level_reg : 8'h00;

  // ----------------------------------------
  // Ladder tap selection
  // ----------------------------------------
  // Tap position over 2^5; disabled ladder outputs the clamped end
  logic [LEVEL_BITS:0] next_num;
  assign next_num = next_cfg.converter_enable ? {1'b0, next_cfg.output_level_select} :
                    (next_cfg.low_power_source_select ? 6'h20 : 6'h00);

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cfg              <= '0;
      ladder_numerator <= '0;
    end
    else
    begin
      cfg              <= next_cfg;
      ladder_numerator <= next_num;
    end
  end

  dref_ladder_ctl u_ladder
  (
    .clk            (clk),
    .rst            (rst),
    .cfg            (cfg),
    .pin_digital_in (pin_level),
    .ana            (ana)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_reset_clears:
    assert property (@(posedge clk) rst |=> ctrl_reg == 8'h00 && level_reg == 8'h00)
    else $error("registers not cleared by reset");

  chk_oe_reset:
    assert property (@(posedge clk) rst |=> !cfg.voltage_output_enable && !ana.pin_analog_mode)
    else $error("output enable set after reset");

  chk_level_reset:
    assert property (@(posedge clk) $past(rst) && !rst |=> cfg.output_level_select == 5'h00)
    else $error("level not cleared after reset");

  chk_enable_bit:
    assert property (@(posedge clk) disable iff (rst)
      wr_ctrl ##1 1'b1 |=> cfg.converter_enable == $past(wr_byte[7], 2))
    else $error("enable bit not following write");

  chk_ctrl_unused:
    assert property (@(posedge clk) (ctrl_reg & 8'h13) == 8'h00)
    else $error("unused control bits set");

  chk_level_unused:
    assert property (@(posedge clk) level_reg[7:5] == 3'h0)
    else $error("unused level bits set");

  chk_level_write:
    assert property (@(posedge clk) disable iff (rst)
      wr_level |=> level_reg == {3'h0, $past(wr_byte[4:0])})
    else $error("level write lost");

  chk_pin_read_zero:
    assert property (@(posedge clk) disable iff (rst)
      ana.pin_analog_mode |-> !ana.pin_digital_read)
    else $error("pin read not zero in voltage mode");

  chk_low_power:
    assert property (@(posedge clk) disable iff (rst)
      !ana.ladder_active |-> ana.connect_positive != ana.connect_negative)
    else $error("low power ladder end wrong");

  chk_tap_value:
    assert property (@(posedge clk) disable iff (rst)
      cfg.converter_enable ##1 $stable(cfg) |-> ladder_numerator == {1'b0, cfg.output_level_select})
    else $error("tap not equal level");

  // Follow checks skip the edge right after reset, which still shows reset values
  chk_ctrl_write:
    assert property (@(posedge clk) disable iff (rst)
      wr_ctrl |=> ctrl_reg == {$past(wr_byte[7:5]), 1'b0, $past(wr_byte[3:2]), 2'b00})
    else $error("control write not stored");

  chk_ctrl_hold:
    assert property (@(posedge clk) disable iff (rst)
      !wr_ctrl |=> $stable(ctrl_reg))
    else $error("control changed without write");

  chk_level_hold:
    assert property (@(posedge clk) disable iff (rst)
      !wr_level |=> $stable(level_reg))
    else $error("level changed without write");

  chk_cfg_reset:
    assert property (@(posedge clk) rst |=> cfg == '0 && ladder_numerator == '0)
    else $error("outputs not cleared by reset");

  chk_src_follow:
    assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> cfg.positive_source_select == $past(ctrl_reg[`DREF_PSS_HI:`DREF_PSS_LO]))
    else $error("source select not following register");

  chk_level_follow:
    assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> cfg.output_level_select == $past(level_reg[`DREF_LVL_HI:`DREF_LVL_LO]))
    else $error("level select not following register");

  chk_ladder_on:
    assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> ana.ladder_active == $past(cfg.converter_enable))
    else $error("ladder state not following enable");

  chk_pin_route:
    assert property (@(posedge clk) disable iff (rst)
      !$past(rst) |-> ana.pin_analog_mode == $past(cfg.voltage_output_enable))
    else $error("pin mode not following output enable");

  chk_pin_passthru:
    assert property (@(posedge clk) disable iff (rst)
      !$past(rst) && !$past(cfg.voltage_output_enable) |-> ana.pin_digital_read == $past(pin_level))
    else $error("pin read lost in digital mode");

  chk_sync_filter:
    assert property (@(posedge clk) disable iff (rst)
      pin_agree |=> pin_level == $past(pin_sync[2]))
    else $error("pin level not taken when stages agree");

endmodule

`default_nettype wire

//--- shared/dref_defs.svh
`ifndef DREF_DEFS_SVH
`define DREF_DEFS_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define DREF_CTRL_ADDR     4'h0
`define DREF_LEVEL_ADDR    4'h4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define DREF_EN_BIT        7
`define DREF_LPS_BIT       6
`define DREF_OE_BIT        5
`define DREF_PSS_HI        3
`define DREF_PSS_LO        2
`define DREF_LVL_HI        4
`define DREF_LVL_LO        0

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define DREF_CTRL_RST      8'h00
`define DREF_LEVEL_RST     8'h00
`define DREF_CTRL_MASK     8'hec
`define DREF_LEVEL_MASK    8'h1f

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define DREF_RESP_OKAY     2'h0
`define DREF_RESP_SLVERR   2'h2

`endif

//--- shared/dref_pkg.sv
`default_nettype none

package dref_pkg;

  typedef enum logic [1:0]
  {
    DREF_SRC_SUPPLY,
    DREF_SRC_EXT_PIN,
    DREF_SRC_FIXED_BUF,
    DREF_SRC_RESERVED
  } dref_src_t;

  typedef struct packed
  {
    logic      converter_enable;
    logic      low_power_source_select;
    logic      voltage_output_enable;
    dref_src_t positive_source_select;
    logic [4:0] output_level_select;
  } dref_cfg_t;

  typedef struct packed
  {
    logic connect_positive;
    logic connect_negative;
    logic ladder_active;
    logic pin_analog_mode;
    logic pin_digital_read;
  } dref_analog_t;

endpackage

`default_nettype wire

//--- rtl/dref_axil_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "dref_defs.svh"

module dref_axil_slave
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wr_strobe,
  output logic [3:0]       wr_addr,
  output logic [7:0]       wr_byte,
  output logic [3:0]       rd_addr,
  input  wire logic [7:0]  rd_byte,
  input  wire logic        rd_hit,
  input  wire logic        wr_hit
);

  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [7:0]  w_byte;
  logic        w_lane0;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire go_wr   = aw_held && w_held && !s_axi_bvalid;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  // Only lane 0 carries data; other lanes are dropped
  assign wr_strobe = go_wr && w_lane0 && wr_hit;
  assign wr_addr   = aw_addr;
  assign wr_byte   = w_byte;
  assign rd_addr   = s_axi_araddr;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DREF_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !aw_held && !aw_take;
      s_axi_wready  <= !w_held && !w_take;
      if (aw_take)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_held  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (go_wr)
      begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `DREF_RESP_OKAY : `DREF_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `DREF_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !ar_take;
      if (ar_take)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_hit ? `DREF_RESP_OKAY : `DREF_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

//--- rtl/dref_ladder_ctl.sv
`timescale 1ns/1ps
`default_nettype none

module dref_ladder_ctl
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire dref_pkg::dref_cfg_t cfg,
  input  wire logic              pin_digital_in,
  output dref_pkg::dref_analog_t ana
);

  dref_pkg::dref_analog_t next_ana;

  // Low-power state drops one end of the ladder; enabled keeps both
  // Digital input detector is overridden while the pin carries the voltage
  assign next_ana =
  '{
    connect_positive: cfg.converter_enable || cfg.low_power_source_select,
    connect_negative: cfg.converter_enable || !cfg.low_power_source_select,
    ladder_active:    cfg.converter_enable,
    pin_analog_mode:  cfg.voltage_output_enable,
    pin_digital_read: pin_digital_in && !cfg.voltage_output_enable
  };

  always_ff @(posedge clk)
  begin
    // Reset state equals the cleared configuration, so no false edge at release
    if (rst)
      ana <= '{connect_negative: 1'b1, default: 1'b0};
    else
      ana <= next_ana;
  end

endmodule

`default_nettype wire

//--- testbench/tb_dref_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "dref_defs.svh"

module tb_dref_regs;
  logic                   clk;
  logic                   rst;
  logic [3:0]             awaddr;
  logic                   awvalid;
  logic                   awready;
  logic [31:0]            wdata;
  logic [3:0]             wstrb;
  logic                   wvalid;
  logic                   wready;
  logic [1:0]             bresp;
  logic                   bvalid;
  logic                   bready;
  logic [3:0]             araddr;
  logic                   arvalid;
  logic                   arready;
  logic [31:0]            rdata;
  logic [1:0]             rresp;
  logic                   rvalid;
  logic                   rready;
  logic                   pin_in;
  dref_pkg::dref_cfg_t    cfg;
  dref_pkg::dref_analog_t ana;
  logic [5:0]             lad;
  int                     error_cnt = 0;
  int                     num_checks = 0;
  logic [1:0]             rsp;
  logic [31:0]            rd;

  dref_regs u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_digital_in(pin_in),
    .cfg(cfg), .ana(ana), .ladder_numerator(lad));

  // ----------------------------------------
  // Common tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Ready sampled at negedge: design only moves on posedge
  task automatic bus_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic pa;
    logic pw;
    logic b;
    int   n;
    pa = 1'b1;
    pw = 1'b1;
    n = 0;
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do
    begin
      @(negedge clk);
      b = bvalid;
      r = bresp;
      if (awvalid && awready) pa = 1'b0;
      if (wvalid && wready) pw = 1'b0;
      @(posedge clk);
      if (!pa) awvalid <= 1'b0;
      if (!pw) wvalid <= 1'b0;
      n++;
    end
    while (!b && n < 100);
    bready <= 1'b0;
    if (!b) check("bvalid", 32'h0, 32'h1);
  endtask

  task automatic bus_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa;
    logic v;
    int   n;
    pa = 1'b1;
    n = 0;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do
    begin
      @(negedge clk);
      v = rvalid;
      d = rdata;
      r = rresp;
      if (arvalid && arready) pa = 1'b0;
      @(posedge clk);
      if (!pa) arvalid <= 1'b0;
      n++;
    end
    while (!v && n < 100);
    rready <= 1'b0;
    if (!v) check("rvalid", 32'h0, 32'h1);
  endtask

  task automatic wr_ok(input logic [3:0] a, input logic [7:0] d);
    bus_wr(a, {24'h0, d}, 4'h1, rsp);
    check("bresp", 32'(rsp), 32'(`DREF_RESP_OKAY));
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    bus_rd(a, rd, rsp);
    check("rdata", rd, {24'h0, exp});
    check("rresp", 32'(rsp), 32'(`DREF_RESP_OKAY));
  endtask

  // cfg trails the register, ana trails cfg
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [31:0] cfg_of(input logic [7:0] c, input logic [7:0] l);
    return {22'h0, c[7:5], c[3:2], l[4:0]};
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk(`DREF_CTRL_ADDR, 8'h00);
    rd_chk(`DREF_LEVEL_ADDR, 8'h00);
    check("cfg", 32'(cfg), 32'h0);
    check("ladder", 32'(lad), 32'h0);
    check("pin_mode", 32'(ana.pin_analog_mode), 32'h0);
    $display("t_reset done");
  endtask

  task automatic t_ctrl();
    wr_ok(`DREF_CTRL_ADDR, 8'hfb);
    rd_chk(`DREF_CTRL_ADDR, 8'he8);
    settle();
    check("cfg", 32'(cfg), cfg_of(8'he8, 8'h00));
    wr_ok(`DREF_CTRL_ADDR, 8'h17);
    rd_chk(`DREF_CTRL_ADDR, 8'h04);
    settle();
    check("cfg", 32'(cfg), cfg_of(8'h04, 8'h00));
    $display("t_ctrl done");
  endtask

  task automatic t_src();
    logic [7:0] c;
    // Code 11 is reserved, software never writes it
    for (int p = 0; p < 3; p++)
    begin
      c = {6'h20, 2'b00} | (8'(p) << 2);
      wr_ok(`DREF_CTRL_ADDR, c);
      rd_chk(`DREF_CTRL_ADDR, c);
      settle();
      check("pss", 32'(cfg.positive_source_select), 32'(p));
    end
    $display("t_src done");
  endtask

  task automatic t_level();
    wr_ok(`DREF_CTRL_ADDR, 8'h80);
    wr_ok(`DREF_LEVEL_ADDR, 8'hff);
    rd_chk(`DREF_LEVEL_ADDR, 8'h1f);
    settle();
    check("ladder", 32'(lad), 32'h1f);
    check("active", 32'(ana.ladder_active), 32'h1);
    wr_ok(`DREF_LEVEL_ADDR, 8'hea);
    rd_chk(`DREF_LEVEL_ADDR, 8'h0a);
    settle();
    check("ladder", 32'(lad), 32'h0a);
    check("cfg", 32'(cfg), cfg_of(8'h80, 8'h0a));
    $display("t_level done");
  endtask

  task automatic t_lowpwr();
    wr_ok(`DREF_CTRL_ADDR, 8'h40);
    settle();
    check("ladder", 32'(lad), 32'h20);
    check("active", 32'(ana.ladder_active), 32'h0);
    check("pos", 32'(ana.connect_positive), 32'h1);
    check("neg", 32'(ana.connect_negative), 32'h0);
    wr_ok(`DREF_CTRL_ADDR, 8'h00);
    settle();
    check("ladder", 32'(lad), 32'h0);
    check("pos", 32'(ana.connect_positive), 32'h0);
    check("neg", 32'(ana.connect_negative), 32'h1);
    $display("t_lowpwr done");
  endtask

  task automatic t_pin();
    @(posedge clk);
    pin_in <= 1'b1;
    wr_ok(`DREF_CTRL_ADDR, 8'h20);
    settle();
    check("pin_mode", 32'(ana.pin_analog_mode), 32'h1);
    check("pin_read", 32'(ana.pin_digital_read), 32'h0);
    wr_ok(`DREF_CTRL_ADDR, 8'h00);
    settle();
    check("pin_mode", 32'(ana.pin_analog_mode), 32'h0);
    check("pin_read", 32'(ana.pin_digital_read), 32'h1);
    pin_in <= 1'b0;
    $display("t_pin done");
  endtask

  task automatic t_buserr();
    bus_wr(4'h8, 32'hff, 4'h1, rsp);
    check("bresp", 32'(rsp), 32'(`DREF_RESP_SLVERR));
    bus_rd(4'h8, rd, rsp);
    check("rresp", 32'(rsp), 32'(`DREF_RESP_SLVERR));
    check("rdata", rd, 32'h0);
    wr_ok(`DREF_LEVEL_ADDR, 8'h07);
    bus_wr(`DREF_LEVEL_ADDR, 32'h1f, 4'h0, rsp);
    check("bresp", 32'(rsp), 32'(`DREF_RESP_OKAY));
    rd_chk(`DREF_LEVEL_ADDR, 8'h07);
    $display("t_buserr done");
  endtask

  task automatic t_midrst();
    wr_ok(`DREF_CTRL_ADDR, 8'he4);
    wr_ok(`DREF_LEVEL_ADDR, 8'h1f);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    check("cfg", 32'(cfg), 32'h0);
    rd_chk(`DREF_CTRL_ADDR, 8'h00);
    rd_chk(`DREF_LEVEL_ADDR, 8'h00);
    $display("t_midrst done");
  endtask

  // ----------------------------------------
  // Clock, sequence, watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    rst = 1'b1;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready, pin_in} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_src();
    t_level();
    t_lowpwr();
    t_pin();
    t_buserr();
    t_midrst();
    test_done();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
